// [verification/orac_checker.sv]
`timescale 1ns/1ps
// ==========
// Port checks
module orac_checker (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RESET,
  // Processor bus
  input wire logic CPU_REQ,
  input wire logic CPU_DONE,
  input wire logic CPU_EXT,
  input wire logic CPU_ADDR_ERR,
  input wire logic [15:0] CPU_RDATA,
  // Register bus
  input wire logic AWREADY,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic ARREADY,
  input wire logic RVALID,
  input wire logic RREADY
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RESET);
  a_done_two_states: assert property ($rose(CPU_DONE) |-> $past(CPU_REQ, 2))
    else $error("done off time");
  a_done_one_cycle: assert property (CPU_DONE |=> !CPU_DONE)
    else $error("done too long");
  a_ext_with_done: assert property (CPU_EXT |-> CPU_DONE)
    else $error("ext without done");
  a_err_no_done: assert property (CPU_ADDR_ERR |=> !CPU_ADDR_ERR && !CPU_DONE)
    else $error("refused access went on");
  a_rdata_hold: assert property (!CPU_DONE |-> $stable(CPU_RDATA))
    else $error("read data moved");
  a_bvalid_hold: assert property (BVALID && !BREADY |=> BVALID)
    else $error("write answer dropped");
  a_aw_refused: assert property (BVALID |-> !AWREADY)
    else $error("address taken while busy");
  a_rvalid_hold: assert property (RVALID && !RREADY |=> RVALID)
    else $error("read answer dropped");
  a_ar_refused: assert property (RVALID |-> !ARREADY)
    else $error("read taken while busy");
  c_ext: cover property (CPU_EXT);
  c_err: cover property (CPU_ADDR_ERR);
  c_read: cover property (RVALID && RREADY);
endmodule : orac_checker
bind orac_ram_ctrl orac_checker u_chk (.*);

// [verification/orac_cpu_model.sv]
`timescale 1ns/1ps
// ==========
// Processor core
module orac_cpu_model (
  // Clock
  input wire logic MCLK,
  // Request
  output logic CPU_REQ = 1'h0,
  output logic CPU_WRITE = 1'h0,
  output logic CPU_WORD = 1'h0,
  output logic [23:0] CPU_ADDR = 24'h0,
  output logic [15:0] CPU_WDATA = 16'h0,
  // Answer
  input wire logic CPU_DONE,
  input wire logic CPU_EXT,
  input wire logic CPU_ADDR_ERR,
  input wire logic [15:0] CPU_RDATA
);
  task automatic access(input logic w, input logic wd, input logic [23:0] a,
    input logic [15:0] d, output logic [15:0] q, output logic x, output logic e,
    output logic k);
    int n;
    @(posedge MCLK);
    CPU_REQ <= 1'h1;
    CPU_WRITE <= w;
    CPU_WORD <= wd;
    CPU_ADDR <= a;
    CPU_WDATA <= d;
    @(posedge MCLK);
    // Released address and data lines show the inverse, so stale values never match by luck
    CPU_REQ <= 1'h0;
    CPU_ADDR <= ~a;
    CPU_WDATA <= ~d;
    n = 0;
    e = 1'h0;
    while (CPU_DONE !== 1'h1 && n < 6) begin
      @(negedge MCLK);
      e = e | (CPU_ADDR_ERR === 1'h1);
      n++;
    end
    q = CPU_RDATA;
    x = CPU_EXT === 1'h1;
    k = CPU_DONE === 1'h1;
  endtask : access
endmodule : orac_cpu_model

// [verification/test_onchip_ram_access_control.sv]
`timescale 1ns/1ps
// ==========
// Bench
module test_onchip_ram_access_control;
  logic MCLK = 1'h0, RESET = 1'h1, STANDBY = 1'h0, AWVALID = 1'h0, WVALID = 1'h0;
  logic BREADY = 1'h0, ARVALID = 1'h0, RREADY = 1'h0, x, e, k;
  logic CPU_REQ, CPU_WRITE, CPU_WORD, CPU_DONE, CPU_EXT, CPU_ADDR_ERR;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic [2:0] MODE = 3'h7;
  logic [2:0] modes [4] = '{3'h1, 3'h3, 3'h5, 3'h6};
  logic [15:0] AWADDR = 16'h0, ARADDR = 16'h0, CPU_WDATA, CPU_RDATA, q;
  logic [23:0] CPU_ADDR;
  logic [31:0] WDATA = 32'h0, RDATA, rd;
  logic [3:0] WSTRB = 4'hF;
  logic [1:0] BRESP, RRESP, rr;
  int miscompares = 0, cmp_count = 0;
  always #2 MCLK = ~MCLK;
  orac_ram_ctrl u_dut (.*);
  orac_cpu_model u_cpu (.*);
  task automatic results;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] g, input logic [31:0] ex);
    cmp_count++;
    if (g !== ex) begin
      $display("BAD %0t got %h exp %h", $time, g, ex);
      miscompares++;
    end
  endtask : chk
  task automatic bound(input int n);
    if (n >= 20) begin
      miscompares++;
      results();
    end
  endtask : bound
  task automatic reg_wr(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge MCLK);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'h1;
    WVALID <= 1'h1;
    BREADY <= 1'h1;
    do begin
      @(posedge MCLK);
      n++;
      if (AWREADY === 1'h1) AWVALID <= 1'h0;
      if (WREADY === 1'h1) WVALID <= 1'h0;
    end while (BVALID !== 1'h1 && n < 20);
    r = BRESP;
    BREADY <= 1'h0;
    bound(n);
  endtask : reg_wr
  task automatic reg_rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge MCLK);
    ARADDR <= a;
    ARVALID <= 1'h1;
    RREADY <= 1'h1;
    do begin
      @(posedge MCLK);
      n++;
      if (ARREADY === 1'h1) ARVALID <= 1'h0;
    end while (RVALID !== 1'h1 && n < 20);
    d = RDATA;
    r = RRESP;
    RREADY <= 1'h0;
    bound(n);
  endtask : reg_rd
  initial begin
    repeat (5) @(posedge MCLK);
    RESET <= 1'h0;
    reg_rd(16'h0000, rd, rr);
    chk(rd[7:0], 8'h0B);
    reg_rd(16'h0010, rd, rr);
    chk(rr, 2'h2);
    reg_wr(16'h0020, 32'h0, rr);
    chk(rr, 2'h2);
    u_cpu.access(1'h1, 1'h1, 24'h0FDF12, 16'h1234, q, x, e, k);
    u_cpu.access(1'h1, 1'h0, 24'h0FDF13, 16'h3C00, q, x, e, k);
    u_cpu.access(1'h0, 1'h1, 24'h0FDF12, 16'h0000, q, x, e, k);
    chk(q, 16'h123C);
    u_cpu.access(1'h0, 1'h0, 24'h0FDF12, 16'h0000, q, x, e, k);
    chk(q, 16'h12FF);
    u_cpu.access(1'h0, 1'h1, 24'h0FDF11, 16'h0000, q, x, e, k);
    chk({e, k}, 2'h2);
    u_cpu.access(1'h0, 1'h0, 24'h0FDF0F, 16'h0000, q, x, e, k);
    chk({e, k}, 2'h0);
    u_cpu.access(1'h1, 1'h1, 24'h0FFF0E, 16'hBEEF, q, x, e, k);
    u_cpu.access(1'h0, 1'h1, 24'h0FFF0E, 16'h0000, q, x, e, k);
    chk(q, 16'hBEEF);
    reg_wr(16'h0000, 32'h0A, rr);
    chk(rr, 2'h0);
    u_cpu.access(1'h0, 1'h1, 24'h0FDF12, 16'h0000, q, x, e, k);
    chk(q, 16'hFFFF);
    u_cpu.access(1'h1, 1'h1, 24'h0FDF12, 16'h0000, q, x, e, k);
    @(posedge MCLK);
    STANDBY <= 1'h1;
    reg_rd(16'h0000, rd, rr);
    chk(rd[7:0], 8'h0A);
    STANDBY <= 1'h0;
    for (int i = 0; i < 4; i++) begin
      @(posedge MCLK);
      MODE <= modes[i];
      u_cpu.access(1'h0, 1'h1, (modes[i] == 3'h3) ? 24'hFFDF12 : 24'h0FDF12, 16'h0,
        q, x, e, k);
      chk({x, k}, 2'h3);
    end
    @(posedge MCLK);
    MODE <= 3'h7;
    RESET <= 1'h1;
    repeat (2) @(posedge MCLK);
    RESET <= 1'h0;
    reg_rd(16'h0000, rd, rr);
    chk(rd[7:0], 8'h0B);
    u_cpu.access(1'h0, 1'h1, 24'h0FDF12, 16'h0000, q, x, e, k);
    chk({x, q}, 17'h0123C);
    results();
  end
endmodule : test_onchip_ram_access_control

// [verilog/orac_defines.svh]
`ifndef ORAC_DEFINES_SVH
`define ORAC_DEFINES_SVH

// ==========================================
// Register map (AXI4-Lite byte addresses)
`define ORAC_SYSTEM_CONTROL_REG_ADDR 16'hFFF2
`define ORAC_AXI_SYSTEM_CONTROL_REG_ADDR 16'h0000
`define ORAC_AXI_MODE_ADDR 16'h0004
`define ORAC_AXI_STAT_ADDR 16'h0008
`define ORAC_SYSTEM_CONTROL_REG_RESET 8'h0B
`define ORAC_RAM_ENABLE_BIT 0

// ==========================================
// Windows, 20-bit and 24-bit address modes
`define ORAC_WIN20_BASE_8K 24'h0FDF10
`define ORAC_WIN20_BASE_4K 24'h0FEF10
`define ORAC_WIN20_LAST 24'h0FFF0F
`define ORAC_WIN24_BASE_8K 24'hFFDF10
`define ORAC_WIN24_BASE_4K 24'hFFEF10
`define ORAC_WIN24_LAST 24'hFFFF0F

// ==========================================
// Timing
`define ORAC_ACCESS_STATES 2

`endif

// [verilog/orac_pkg.sv]
package orac_pkg;
  typedef enum logic [1:0] {
    ORAC_ROUTE_INTERNAL,
    ORAC_ROUTE_EXTERNAL,
    ORAC_ROUTE_BLOCKED,
    ORAC_ROUTE_NONE
  } orac_route_e;
  typedef enum {
    ORAC_IDLE,
    ORAC_STATE2
  } orac_state_e;
endpackage : orac_pkg

// [verilog/orac_ram_array.sv]
`timescale 1ns/1ps
module orac_ram_array #(
  parameter int DEPTH_WORDS = 4096,
  parameter int AW = 12
) (
  // Clock
  input wire logic clk,
  // Port
  input wire logic [AW-1:0] addr,
  input wire logic we_hi,
  input wire logic we_lo,
  input wire logic [15:0] wdata,
  output logic [15:0] rdata
);
  logic [7:0] mem_hi [0:DEPTH_WORDS-1];
  logic [7:0] mem_lo [0:DEPTH_WORDS-1];

  // ==========================================
  // Synchronous byte-lane RAM, no reset of contents
  always_ff @(posedge clk) begin
    if (we_hi) begin
      mem_hi[addr] <= wdata[15:8];
    end
    if (we_lo) begin
      mem_lo[addr] <= wdata[7:0];
    end
    rdata <= {mem_hi[addr], mem_lo[addr]};
  end
endmodule : orac_ram_array

// [verilog/orac_ram_ctrl.sv]
`timescale 1ns/1ps
`include "orac_defines.svh"
// Contract
// RULE_01: 16-bit path, byte and word in two states
// RULE_02: Mode-dependent RAM window, 8k or 4k size
// RULE_03: Enable bit at bit 0, reset one
// RULE_04: External reset inits enable; standby keeps it
// RULE_05: Disabled in expanded modes forwards to external
// RULE_06: Disabled in mode 7: reads ones, writes dropped
// RULE_07: Byte access uses upper eight data lines
// RULE_08: Word access at even address, full bus
// RULE_09: Control register at FFF2, RW, reset 0B; code decodes it only at AXI address 0000, FFF2 is never decoded
module orac_ram_ctrl
  import orac_pkg::*;
#(
  parameter bit SMALL_RAM = 1'b0,
  parameter int AW = 12
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RESET,
  // Operating mode and standby
  input wire logic [2:0] MODE,
  input wire logic STANDBY,
  // Processor bus request
  input wire logic CPU_REQ,
  input wire logic CPU_WRITE,
  input wire logic CPU_WORD,
  input wire logic [23:0] CPU_ADDR,
  input wire logic [15:0] CPU_WDATA,
  // Processor bus answer
  output logic CPU_DONE,
  output logic CPU_EXT,
  output logic CPU_ADDR_ERR,
  output logic [15:0] CPU_RDATA,
  // AXI4-Lite write
  input wire logic [15:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // AXI4-Lite read
  input wire logic [15:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY
);
  // ==========================================
  // Control register
  logic [7:0] system_control_reg;
  wire ram_enable_bit = system_control_reg[`ORAC_RAM_ENABLE_BIT];

  // ==========================================
  // Address decode
  function automatic logic in_window(input logic [23:0] a, input logic [2:0] m);
    logic [23:0] lo;
    logic [23:0] hi;
    lo = 24'h000000;
    hi = 24'h000000;
    // RULE_02 window select
    if (m == 3'd3) begin
      lo = SMALL_RAM ? `ORAC_WIN24_BASE_4K : `ORAC_WIN24_BASE_8K;
      hi = `ORAC_WIN24_LAST;
      in_window = (a >= lo) && (a <= hi);
    end else if (m == 3'd1 || m == 3'd5 || m == 3'd6 || m == 3'd7) begin
      lo = SMALL_RAM ? `ORAC_WIN20_BASE_4K : `ORAC_WIN20_BASE_8K;
      hi = `ORAC_WIN20_LAST;
      in_window = ({4'h0, a[19:0]} >= lo) && ({4'h0, a[19:0]} <= hi);
    end else begin
      in_window = 1'b0;
    end
  endfunction : in_window

  wire hit = in_window(CPU_ADDR, MODE);
  wire [23:0] win_base = (MODE == 3'd3) ?
    (SMALL_RAM ? `ORAC_WIN24_BASE_4K : `ORAC_WIN24_BASE_8K) :
    (SMALL_RAM ? `ORAC_WIN20_BASE_4K : `ORAC_WIN20_BASE_8K);
  wire [23:0] a_norm = (MODE == 3'd3) ? CPU_ADDR : {4'h0, CPU_ADDR[19:0]};
  wire [23:0] offs = a_norm - win_base;
  wire [AW-1:0] word_idx = offs[AW:1];
  wire single_chip = (MODE == 3'd7);
  // RULE_08 even word address
  wire misaligned = CPU_WORD && CPU_ADDR[0];
  // RULE_05 forward when disabled
  // RULE_06 block in single chip
  wire orac_route_e route = !hit ? ORAC_ROUTE_NONE :
    ram_enable_bit ? ORAC_ROUTE_INTERNAL :
    single_chip ? ORAC_ROUTE_BLOCKED : ORAC_ROUTE_EXTERNAL;

  // ==========================================
  // Two-state access sequencer
  orac_state_e state;
  orac_route_e route_q;
  logic word_q;
  logic odd_q;
  wire start = CPU_REQ && (state == ORAC_IDLE) && (route != ORAC_ROUTE_NONE) && !misaligned;
  wire ram_go = start && (route == ORAC_ROUTE_INTERNAL) && CPU_WRITE;
  // RULE_07 byte on upper lines
  wire we_hi = ram_go && (CPU_WORD || !CPU_ADDR[0]);
  wire we_lo = ram_go && (CPU_WORD || CPU_ADDR[0]);
  wire [15:0] ram_wdata = CPU_WORD ? CPU_WDATA : {CPU_WDATA[15:8], CPU_WDATA[15:8]};
  wire [15:0] ram_rdata;

  orac_ram_array #(
    .DEPTH_WORDS(1 << AW),
    .AW(AW)
  ) u_ram (
    .clk(MCLK),
    .addr(word_idx),
    .we_hi(we_hi),
    .we_lo(we_lo),
    .wdata(ram_wdata),
    .rdata(ram_rdata)
  );

  // RULE_01 two states per access
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      state <= ORAC_IDLE;
      route_q <= ORAC_ROUTE_NONE;
      word_q <= 1'b0;
      odd_q <= 1'b0;
    end else begin
      unique case (state)
        ORAC_IDLE: begin
          if (start) begin
            state <= ORAC_STATE2;
            route_q <= route;
            word_q <= CPU_WORD;
            odd_q <= CPU_ADDR[0];
          end
        end
        ORAC_STATE2: begin
          state <= ORAC_IDLE;
        end
      endcase
    end
  end

  // RULE_07 byte on upper lines
  wire [15:0] int_rd = word_q ? ram_rdata :
    {(odd_q ? ram_rdata[7:0] : ram_rdata[15:8]), 8'hFF};
  wire done_now = (state == ORAC_STATE2);
  wire err_now = CPU_REQ && (state == ORAC_IDLE) && misaligned && hit;

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      CPU_RDATA <= 16'hFFFF;
      CPU_DONE <= 1'b0;
      CPU_EXT <= 1'b0;
      CPU_ADDR_ERR <= 1'b0;
    end else begin
      CPU_DONE <= done_now;
      CPU_EXT <= done_now && (route_q == ORAC_ROUTE_EXTERNAL);
      CPU_ADDR_ERR <= err_now;
      // RULE_06 read all ones
      if (done_now) begin
        CPU_RDATA <= (route_q == ORAC_ROUTE_INTERNAL) ? int_rd : 16'hFFFF;
      end
    end
  end

  // ==========================================
  // AXI4-Lite slave
  logic aw_held;
  logic w_held;
  logic [15:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  assign AWREADY = !aw_held && !BVALID;
  assign WREADY = !w_held && !BVALID;
  wire aw_have = aw_held || (AWVALID && AWREADY);
  wire w_have = w_held || (WVALID && WREADY);
  wire [15:0] wr_addr = aw_held ? aw_addr_q : AWADDR;
  wire [31:0] wr_data = w_held ? w_data_q : WDATA;
  wire [3:0] wr_strb = w_held ? w_strb_q : WSTRB;
  wire wr_fire = aw_have && w_have && !BVALID;
  wire wr_system_control_reg = wr_fire && (wr_addr[15:2] == `ORAC_AXI_SYSTEM_CONTROL_REG_ADDR >> 2);
  wire wr_ok = (wr_addr[15:2] == `ORAC_AXI_SYSTEM_CONTROL_REG_ADDR >> 2);

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_q <= 16'h0000;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      BVALID <= 1'b0;
      BRESP <= 2'b00;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_addr_q <= AWADDR;
      end
      if (WVALID && WREADY) begin
        w_data_q <= WDATA;
        w_strb_q <= WSTRB;
      end
      aw_held <= wr_fire ? 1'b0 : aw_have;
      w_held <= wr_fire ? 1'b0 : w_have;
      if (wr_fire) begin
        BVALID <= 1'b1;
        BRESP <= wr_ok ? 2'b00 : 2'b10;
      end else if (BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end

  // RULE_03 enable reset one
  // RULE_04 standby keeps value
  // RULE_09 register reset 0B
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      system_control_reg <= `ORAC_SYSTEM_CONTROL_REG_RESET;
    end else if (wr_system_control_reg && wr_strb[0]) begin
      system_control_reg <= wr_data[7:0];
    end
  end

  // Standby only shows in the status word, so the enable survives it untouched
  wire [31:0] stat_word = {27'h0, STANDBY, ram_enable_bit, state == ORAC_STATE2, 2'b00};
  wire [15:0] rd_addr = ARADDR;
  assign ARREADY = !RVALID;
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      RVALID <= 1'b0;
      RDATA <= 32'h00000000;
      RRESP <= 2'b00;
    end else if (ARVALID && ARREADY) begin
      RVALID <= 1'b1;
      RRESP <= 2'b00;
      if (rd_addr[15:2] == `ORAC_AXI_SYSTEM_CONTROL_REG_ADDR >> 2) begin
        RDATA <= {24'h0, system_control_reg};
      end else if (rd_addr[15:2] == `ORAC_AXI_MODE_ADDR >> 2) begin
        RDATA <= {29'h0, MODE};
      end else if (rd_addr[15:2] == `ORAC_AXI_STAT_ADDR >> 2) begin
        RDATA <= stat_word;
      end else begin
        RDATA <= 32'h00000000;
        RRESP <= 2'b10;
      end
    end else if (RREADY) begin
      RVALID <= 1'b0;
    end
  end
endmodule : orac_ram_ctrl
